/* tbcs_defs.svh */
/*
 * Register offsets, field positions, reset values and response codes for the
 * timer-two control block. Assumes it is included by bare name.
 */
`ifndef TBCS_DEFS_SVH
`define TBCS_DEFS_SVH

`define TBCS_OFF_CTRL 8'hc8
`define TBCS_OFF_COUNT 8'hcc
`define TBCS_OFF_RELOAD 8'hd0
`define TBCS_OFF_CAPTURE 8'hd4
`define TBCS_OFF_IRQ_STATUS 8'hd8
`define TBCS_OFF_IRQ_ENABLE 8'hdc
`define TBCS_OFF_IRQ_CLEAR 8'he0
`define TBCS_OFF_SERIAL 8'he4

`define TBCS_CTRL_RESET 8'h00
`define TBCS_BIT_OVF 7
`define TBCS_BIT_EXT 6
`define TBCS_BIT_RCLK 5
`define TBCS_BIT_TX_CLOCK_SELECT 4
`define TBCS_BIT_EXEN 3
`define TBCS_BIT_RUN 2
`define TBCS_BIT_CSRC 1
`define TBCS_BIT_CAPRL 0

`define TBCS_SER_BIT_MODE0SRC 0

`define TBCS_IRQ_OVF 0
`define TBCS_IRQ_EXT 1
`define TBCS_IRQ_WIDTH 2

`define TBCS_RESP_OKAY 2'b00
`define TBCS_RESP_SLVERR 2'b10

`endif

/* tbcs_pin_sync.sv */
/*
 * Three-stage synchroniser for a pin input, with falling-edge detection.
 * Assumes the pin is asynchronous to ref_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module tbcs_pin_sync (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Pin and result.
    input wire logic pinIn,
    output logic level,
    output logic fallEdge
);
    logic [2:0] sync_r;
    logic [2:0] sync_nxt;
    logic level_r;
    logic level_nxt;
    logic fall_r;
    logic fall_nxt;

    // A change counts once stages two and three agree.
    always_comb begin
        sync_nxt = {sync_r[1:0], pinIn};
        level_nxt = level_r;
        fall_nxt = 1'b0;
        if (sync_r[1] == sync_r[2]) begin
            level_nxt = sync_r[2];
            fall_nxt = level_r & ~sync_r[2];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync_r <= 3'b111;
            level_r <= 1'b1;
            fall_r <= 1'b0;
        end else begin
            sync_r <= sync_nxt;
            level_r <= level_nxt;
            fall_r <= fall_nxt;
        end
    end

    assign level = level_r;
    assign fallEdge = fall_r;
endmodule : tbcs_pin_sync
`default_nettype wire

/* tbcs_pkg.sv */
/*
 * Types shared by the timer-two control block.
 * Assumes tbcs_defs.svh is compiled alongside.
 */
package tbcs_pkg;

    typedef enum logic [1:0] {
        TBCS_W_IDLE = 2'b00,
        TBCS_W_RESP = 2'b01
    } tbcs_wstate_t;

endpackage : tbcs_pkg

/* tbcs_serial_partner.sv */
/* Far-side serial clock logic: sends source ticks while enabled and
   counts ticks sent and clocks returned. Assumes one ref_clk domain. */
`timescale 1ns/10ps
`default_nettype none
module tbcs_serial_partner (
    // Clock, reset and enable.
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic tickEn,
    // Ticks to the block.
    output logic timerOneOverflow,
    output logic baudGenTick,
    output logic mode0DefaultTick,
    // Clocks from the block.
    input wire logic serialRxClock,
    input wire logic serialTxClock,
    // Counts.
    output var int t1Cnt,
    output var int bgCnt,
    output var int m0Cnt,
    output var int rxCnt,
    output var int txCnt
);
    int phase;

    // Coprime periods keep the three sources apart most of the time.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase <= 0;
            timerOneOverflow <= 1'b0;
            baudGenTick <= 1'b0;
            mode0DefaultTick <= 1'b0;
            t1Cnt <= 0;
            bgCnt <= 0;
            m0Cnt <= 0;
            rxCnt <= 0;
            txCnt <= 0;
        end else begin
            phase <= phase + 1;
            timerOneOverflow <= tickEn && phase % 5 == 0;
            baudGenTick <= tickEn && phase % 7 == 1;
            mode0DefaultTick <= tickEn && phase % 3 == 2;
            t1Cnt <= t1Cnt + int'(timerOneOverflow);
            bgCnt <= bgCnt + int'(baudGenTick);
            m0Cnt <= m0Cnt + int'(mode0DefaultTick);
            rxCnt <= rxCnt + int'(serialRxClock);
            txCnt <= txCnt + int'(serialTxClock);
        end
    end
endmodule : tbcs_serial_partner
`default_nettype wire

/* tbcs_timer.sv */
/*
 * Timer-two control: 16-bit timer/counter with capture/reload, trigger
 * flag and serial clock selection, behind an AXI4-Lite slave.
 * Assumes a single ref_clk domain; pins are asynchronous.
 */
//
// Function
// - Overflow sets overflow flag only when both clock selects are zero; software clears.
// - Trigger flag with interrupt enabled raises the timer interrupt.
// - Receive clock select picks timer 1 or this timer overflow.
// - Count source zero counts the peripheral clock.
// - Count source one counts falling edges on the count pin.
// - Internal baud generator may clock modes 1, 3, and mode 0 if selected.
// - Control register resets to zero and is written as a whole byte when strobe bit 0 is set.
`include "tbcs_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module tbcs_timer
    import tbcs_pkg::*;
#(
    parameter int CNT_WIDTH = 16
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // AXI4-Lite write address.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins.
    input wire logic externalCountPin,
    input wire logic externalTriggerPin,
    // Serial port clock sources.
    input wire logic timerOneOverflow,
    input wire logic baudGenTick,
    input wire logic baudGenRxSelect,
    input wire logic baudGenTxSelect,
    input wire logic mode0DefaultTick,
    input wire logic [1:0] serialMode,
    output logic serialRxClock,
    output logic serialTxClock,
    // Interrupt.
    output logic timerIrq
);
    logic countLevel;
    logic countFall;
    logic trigLevel;
    logic trigFall;

    tbcs_pin_sync countSync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pinIn(externalCountPin),
        .level(countLevel),
        .fallEdge(countFall)
    );

    tbcs_pin_sync trigSync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pinIn(externalTriggerPin),
        .level(trigLevel),
        .fallEdge(trigFall)
    );

    logic [7:0] ctrl_r, ctrl_nxt;
    logic [CNT_WIDTH-1:0] count_r, count_nxt;
    logic [CNT_WIDTH-1:0] reload_r, reload_nxt;
    logic [CNT_WIDTH-1:0] capture_r, capture_nxt;
    logic [`TBCS_IRQ_WIDTH-1:0] irqStat_r, irqStat_nxt;
    logic [`TBCS_IRQ_WIDTH-1:0] irqEn_r, irqEn_nxt;
    logic mode0Src_r, mode0Src_nxt;
    logic rxClk_r, rxClk_nxt;
    logic txClk_r, txClk_nxt;
    logic irq_r, irq_nxt;

    tbcs_wstate_t wState_r, wState_nxt;
    logic awTaken_r, awTaken_nxt;
    logic wTaken_r, wTaken_nxt;
    logic [7:0] wAddr_r, wAddr_nxt;
    logic [31:0] wData_r, wData_nxt;
    logic [3:0] wStrb_r, wStrb_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rValid_r, rValid_nxt;
    logic [31:0] rData_r, rData_nxt;
    logic [1:0] rResp_r, rResp_nxt;
    logic awReady_r, awReady_nxt;
    logic wReady_r, wReady_nxt;
    logic arReady_r, arReady_nxt;

    // Register decode shared by the read and write paths.
    function automatic logic addrMapped(input logic [7:0] a);
        case (a)
            `TBCS_OFF_CTRL, `TBCS_OFF_COUNT, `TBCS_OFF_RELOAD, `TBCS_OFF_CAPTURE,
            `TBCS_OFF_IRQ_STATUS, `TBCS_OFF_IRQ_ENABLE, `TBCS_OFF_IRQ_CLEAR,
            `TBCS_OFF_SERIAL: addrMapped = 1'b1;
            default: addrMapped = 1'b0;
        endcase
    endfunction : addrMapped

    logic doWrite;
    logic [7:0] ctrlWr;
    logic ovfSelClear;
    logic tick;
    logic overflow;
    logic trigEvent;
    logic clockMode;

    // Write path: address and data taken in either order, then one response.
    always_comb begin
        wState_nxt = wState_r;
        awTaken_nxt = awTaken_r;
        wTaken_nxt = wTaken_r;
        wAddr_nxt = wAddr_r;
        wData_nxt = wData_r;
        wStrb_nxt = wStrb_r;
        bresp_nxt = bresp_r;
        doWrite = 1'b0;
        case (wState_r)
            TBCS_W_IDLE: begin
                if (s_axi_awvalid && awReady_r) begin
                    awTaken_nxt = 1'b1;
                    wAddr_nxt = {s_axi_awaddr[7:2], 2'b00};
                end
                if (s_axi_wvalid && wReady_r) begin
                    wTaken_nxt = 1'b1;
                    wData_nxt = s_axi_wdata;
                    wStrb_nxt = s_axi_wstrb;
                end
                if (awTaken_r && wTaken_r) begin
                    doWrite = 1'b1;
                    bresp_nxt = addrMapped(wAddr_r) ? `TBCS_RESP_OKAY : `TBCS_RESP_SLVERR;
                    wState_nxt = TBCS_W_RESP;
                end
            end
            TBCS_W_RESP: begin
                if (s_axi_bready) begin
                    awTaken_nxt = 1'b0;
                    wTaken_nxt = 1'b0;
                    wState_nxt = TBCS_W_IDLE;
                end
            end
            default: wState_nxt = TBCS_W_IDLE;
        endcase
    end

    // Read path: one read at a time, answered the cycle after the address.
    always_comb begin
        rValid_nxt = rValid_r;
        rData_nxt = rData_r;
        rResp_nxt = rResp_r;
        if (rValid_r && s_axi_rready) begin
            rValid_nxt = 1'b0;
        end else if (s_axi_arvalid && arReady_r) begin
            rValid_nxt = 1'b1;
            rResp_nxt = addrMapped({s_axi_araddr[7:2], 2'b00}) ?
                `TBCS_RESP_OKAY : `TBCS_RESP_SLVERR;
            case ({s_axi_araddr[7:2], 2'b00})
                `TBCS_OFF_CTRL: rData_nxt = {24'h000000, ctrl_r};
                `TBCS_OFF_COUNT: rData_nxt = 32'(count_r);
                `TBCS_OFF_RELOAD: rData_nxt = 32'(reload_r);
                `TBCS_OFF_CAPTURE: rData_nxt = 32'(capture_r);
                `TBCS_OFF_IRQ_STATUS: rData_nxt = 32'(irqStat_r);
                `TBCS_OFF_IRQ_ENABLE: rData_nxt = 32'(irqEn_r);
                `TBCS_OFF_SERIAL: rData_nxt = {31'h00000000, mode0Src_r};
                default: rData_nxt = 32'h00000000;
            endcase
        end
    end

    // Timer core, flags and clock selection.
    always_comb begin
        ctrlWr = ctrl_r;
        if (doWrite && wAddr_r == `TBCS_OFF_CTRL && wStrb_r[0]) begin
            ctrlWr = wData_r[7:0];
        end
        clockMode = ctrl_r[`TBCS_BIT_RCLK] | ctrl_r[`TBCS_BIT_TX_CLOCK_SELECT];
        ovfSelClear = !clockMode;
        tick = ctrl_r[`TBCS_BIT_CSRC] ? countFall : 1'b1;
        tick = tick & ctrl_r[`TBCS_BIT_RUN];
        overflow = tick && (count_r == {CNT_WIDTH{1'b1}});
        trigEvent = trigFall && ctrl_r[`TBCS_BIT_EXEN];

        count_nxt = count_r;
        reload_nxt = reload_r;
        capture_nxt = capture_r;
        if (tick) begin
            count_nxt = count_r + 1'b1;
        end
        // Clock mode always reloads; otherwise the capture/reload bit decides.
        if (overflow && (clockMode || !ctrl_r[`TBCS_BIT_CAPRL])) begin
            count_nxt = reload_r;
        end
        if (trigEvent && !clockMode) begin
            if (ctrl_r[`TBCS_BIT_CAPRL]) begin
                capture_nxt = count_r;
            end else begin
                count_nxt = reload_r;
            end
        end
        if (doWrite && wAddr_r == `TBCS_OFF_COUNT) begin
            count_nxt = wData_r[CNT_WIDTH-1:0];
        end
        if (doWrite && wAddr_r == `TBCS_OFF_RELOAD) begin
            reload_nxt = wData_r[CNT_WIDTH-1:0];
        end

        ctrl_nxt = ctrlWr;
        // A hardware set wins over a software clear in the same cycle.
        if (overflow && ovfSelClear) begin
            ctrl_nxt[`TBCS_BIT_OVF] = 1'b1;
        end
        if (trigEvent) begin
            ctrl_nxt[`TBCS_BIT_EXT] = 1'b1;
        end

        irqEn_nxt = irqEn_r;
        mode0Src_nxt = mode0Src_r;
        irqStat_nxt = irqStat_r;
        if (doWrite && wAddr_r == `TBCS_OFF_IRQ_ENABLE) begin
            irqEn_nxt = wData_r[`TBCS_IRQ_WIDTH-1:0];
        end
        if (doWrite && wAddr_r == `TBCS_OFF_SERIAL) begin
            mode0Src_nxt = wData_r[`TBCS_SER_BIT_MODE0SRC];
        end
        if (doWrite && wAddr_r == `TBCS_OFF_IRQ_CLEAR) begin
            irqStat_nxt = irqStat_r & ~wData_r[`TBCS_IRQ_WIDTH-1:0];
        end
        if (overflow && ovfSelClear) begin
            irqStat_nxt[`TBCS_IRQ_OVF] = 1'b1;
        end
        if (trigEvent) begin
            irqStat_nxt[`TBCS_IRQ_EXT] = 1'b1;
        end
        // Control flags also request the interrupt while enabled.
        irq_nxt = |(irqStat_nxt & irqEn_nxt)
            | (ctrl_nxt[`TBCS_BIT_EXT] & irqEn_nxt[`TBCS_IRQ_EXT])
            | (ctrl_nxt[`TBCS_BIT_OVF] & irqEn_nxt[`TBCS_IRQ_OVF]);

        // Modes 1 and 3 pick among baud generator, timer 1 and this timer.
        if (serialMode == 2'd1 || serialMode == 2'd3) begin
            if (baudGenRxSelect) begin
                rxClk_nxt = baudGenTick;
            end else begin
                rxClk_nxt = ctrl_r[`TBCS_BIT_RCLK] ? overflow : timerOneOverflow;
            end
            if (baudGenTxSelect) begin
                txClk_nxt = baudGenTick;
            end else begin
                txClk_nxt = ctrl_r[`TBCS_BIT_TX_CLOCK_SELECT] ? overflow : timerOneOverflow;
            end
        end else if (serialMode == 2'd0) begin
            rxClk_nxt = mode0Src_r ? baudGenTick : mode0DefaultTick;
            txClk_nxt = rxClk_nxt;
        end else begin
            rxClk_nxt = 1'b0;
            txClk_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= `TBCS_CTRL_RESET;
            count_r <= '0;
            reload_r <= '0;
            capture_r <= '0;
            irqStat_r <= '0;
            irqEn_r <= '0;
            mode0Src_r <= 1'b0;
            rxClk_r <= 1'b0;
            txClk_r <= 1'b0;
            irq_r <= 1'b0;
            wState_r <= TBCS_W_IDLE;
            awTaken_r <= 1'b0;
            wTaken_r <= 1'b0;
            wAddr_r <= 8'h00;
            wData_r <= 32'h00000000;
            wStrb_r <= 4'h0;
            bresp_r <= 2'b00;
            rValid_r <= 1'b0;
            rData_r <= 32'h00000000;
            rResp_r <= 2'b00;
        end else begin
            ctrl_r <= ctrl_nxt;
            count_r <= count_nxt;
            reload_r <= reload_nxt;
            capture_r <= capture_nxt;
            irqStat_r <= irqStat_nxt;
            irqEn_r <= irqEn_nxt;
            mode0Src_r <= mode0Src_nxt;
            rxClk_r <= rxClk_nxt;
            txClk_r <= txClk_nxt;
            irq_r <= irq_nxt;
            wState_r <= wState_nxt;
            awTaken_r <= awTaken_nxt;
            wTaken_r <= wTaken_nxt;
            wAddr_r <= wAddr_nxt;
            wData_r <= wData_nxt;
            wStrb_r <= wStrb_nxt;
            bresp_r <= bresp_nxt;
            rValid_r <= rValid_nxt;
            rData_r <= rData_nxt;
            rResp_r <= rResp_nxt;
        end
    end

    // Ready is high while a channel can take an item; it drops once the item is taken.
    always_comb begin
        awReady_nxt = (wState_nxt == TBCS_W_IDLE) && !awTaken_nxt;
        wReady_nxt = (wState_nxt == TBCS_W_IDLE) && !wTaken_nxt;
        arReady_nxt = !rValid_nxt;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            awReady_r <= 1'b0;
            wReady_r <= 1'b0;
            arReady_r <= 1'b0;
        end else begin
            awReady_r <= awReady_nxt;
            wReady_r <= wReady_nxt;
            arReady_r <= arReady_nxt;
        end
    end

    assign s_axi_awready = awReady_r;
    assign s_axi_wready = wReady_r;
    assign s_axi_bvalid = (wState_r == TBCS_W_RESP);
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arReady_r;
    assign s_axi_rvalid = rValid_r;
    assign s_axi_rdata = rData_r;
    assign s_axi_rresp = rResp_r;
    assign serialRxClock = rxClk_r;
    assign serialTxClock = txClk_r;
    assign timerIrq = irq_r;
endmodule : tbcs_timer
`default_nettype wire

/* tbcs_timer_properties.sv */
/* Port assertions for the timer-two control block.
   Assumes it is bound to tbcs_timer in one ref_clk domain. */
`timescale 1ns/10ps
`default_nettype none
module tbcs_timer_properties #(
    parameter int CNT_WIDTH = 16
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Register bus.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins and serial clocks.
    input wire logic externalCountPin,
    input wire logic externalTriggerPin,
    input wire logic timerOneOverflow,
    input wire logic baudGenTick,
    input wire logic baudGenRxSelect,
    input wire logic baudGenTxSelect,
    input wire logic mode0DefaultTick,
    input wire logic [1:0] serialMode,
    input wire logic serialRxClock,
    input wire logic serialTxClock,
    input wire logic timerIrq
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    resp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    read_latency_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    write_resp_a: assert property (
        s_axi_wvalid && s_axi_wready |-> ##[0:8] s_axi_bvalid)
        else $error("write response missing");
    resp_code_a: assert property (
        s_axi_bvalid |-> s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10)
        else $error("bad write response code");
    rx_baud_a: assert property (
        baudGenRxSelect && serialMode[0] && baudGenTick |=> serialRxClock)
        else $error("rx clock missed baud tick");
    tx_baud_a: assert property (
        baudGenTxSelect && serialMode[0] && baudGenTick |=> serialTxClock)
        else $error("tx clock missed baud tick");
    reset_quiet_a: assert property (
        $fell(rst) |-> !timerIrq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active after reset");
endmodule : tbcs_timer_properties

bind tbcs_timer tbcs_timer_properties #(.CNT_WIDTH(CNT_WIDTH)) i_props (.*);
`default_nettype wire

/* timer2_baud_clock_select_tb_top.sv */
/* Self-checking bench for the timer-two control block.
   Assumes tbcs_defs.svh and the serial partner model are compiled. */
`include "tbcs_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module timer2_baud_clock_select_tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic externalCountPin = 1'b1;
    logic externalTriggerPin = 1'b1;
    logic timerOneOverflow, baudGenTick, mode0DefaultTick, serialRxClock, serialTxClock;
    logic baudGenRxSelect = 1'b0;
    logic baudGenTxSelect = 1'b0;
    logic [1:0] serialMode = 2'h0;
    logic timerIrq;
    logic tickEn = 1'b0;
    int t1Cnt, bgCnt, m0Cnt, rxCnt, txCnt;
    int error_cnt = 0;
    int tests_run = 0;

    always #25 ref_clk = ~ref_clk;

    tbcs_timer #(.CNT_WIDTH(16)) i_dut (.*);
    tbcs_serial_partner i_far (.ref_clk(ref_clk), .rst(rst), .tickEn(tickEn),
        .timerOneOverflow(timerOneOverflow), .baudGenTick(baudGenTick),
        .mode0DefaultTick(mode0DefaultTick), .serialRxClock(serialRxClock),
        .serialTxClock(serialTxClock), .t1Cnt(t1Cnt), .bgCnt(bgCnt),
        .m0Cnt(m0Cnt), .rxCnt(rxCnt), .txCnt(txCnt));

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        while (aw || w) begin
            @(posedge ref_clk);
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        while (s_axi_rvalid !== 1'b1) @(posedge ref_clk);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask : rd

    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        close_out();
    end

    initial begin
        logic [31:0] v, c0;
        logic [1:0] r;
        int a0, a1, e0, e1, t0;
        int mode[4] = '{1, 1, 0, 0};
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(`TBCS_OFF_CTRL, v);
        chk(v, 32'h0);
        wr(`TBCS_OFF_COUNT, 32'h1234, r);
        repeat (5) @(posedge ref_clk);
        rd(`TBCS_OFF_COUNT, v);
        chk(v, 32'h1234);
        // Overflow on the peripheral clock raises the flag and the interrupt.
        wr(`TBCS_OFF_COUNT, 32'hfff0, r);
        wr(`TBCS_OFF_CTRL, 32'h04, r);
        repeat (30) @(posedge ref_clk);
        rd(`TBCS_OFF_CTRL, v);
        chk(v, 32'h84);
        wr(`TBCS_OFF_IRQ_ENABLE, 32'h3, r);
        repeat (2) @(posedge ref_clk);
        chk(timerIrq, 1'b1);
        wr(`TBCS_OFF_CTRL, 32'h00, r);
        wr(`TBCS_OFF_IRQ_CLEAR, 32'h3, r);
        repeat (2) @(posedge ref_clk);
        chk(timerIrq, 1'b0);
        // Counter mode: each pin fall adds one.
        wr(`TBCS_OFF_CTRL, 32'h06, r);
        rd(`TBCS_OFF_COUNT, c0);
        repeat (5) begin
            externalCountPin <= 1'b0;
            repeat (6) @(posedge ref_clk);
            externalCountPin <= 1'b1;
            repeat (6) @(posedge ref_clk);
        end
        rd(`TBCS_OFF_COUNT, v);
        chk(v[15:0], c0[15:0] + 16'h5);
        // A trigger fall with the enable set raises the trigger flag.
        wr(`TBCS_OFF_CTRL, 32'h08, r);
        externalTriggerPin <= 1'b0;
        repeat (8) @(posedge ref_clk);
        externalTriggerPin <= 1'b1;
        rd(`TBCS_OFF_CTRL, v);
        chk(v, 32'h48);
        chk(timerIrq, 1'b1);
        wr(`TBCS_OFF_CTRL, 32'h00, r);
        wr(`TBCS_OFF_IRQ_CLEAR, 32'h3, r);
        // Timer as both serial clocks: no flag, one clock each way.
        serialMode <= 2'h1;
        a0 = rxCnt;
        e0 = txCnt;
        wr(`TBCS_OFF_COUNT, 32'hfff0, r);
        wr(`TBCS_OFF_CTRL, 32'h34, r);
        repeat (30) @(posedge ref_clk);
        rd(`TBCS_OFF_CTRL, v);
        chk(v, 32'h34);
        chk(rxCnt - a0, 1);
        chk(txCnt - e0, 1);
        wr(`TBCS_OFF_CTRL, 32'h00, r);
        // Source table: timer one, baud generator, mode 0 default and selected.
        for (int i = 0; i < 4; i++) begin
            serialMode <= mode[i][1:0];
            baudGenRxSelect <= (i == 1);
            baudGenTxSelect <= (i == 1);
            wr(`TBCS_OFF_SERIAL, {31'h0, i == 3}, r);
            a0 = rxCnt;
            t0 = txCnt;
            e0 = (i == 0) ? t1Cnt : (i == 2) ? m0Cnt : bgCnt;
            tickEn <= 1'b1;
            repeat (60) @(posedge ref_clk);
            tickEn <= 1'b0;
            repeat (6) @(posedge ref_clk);
            a1 = rxCnt;
            e1 = (i == 0) ? t1Cnt : (i == 2) ? m0Cnt : bgCnt;
            chk(a1 - a0, e1 - e0);
            chk(txCnt - t0, e1 - e0);
        end
        wr(8'h00, 32'h0, r);
        chk(r, `TBCS_RESP_SLVERR);
        close_out();
    end
endmodule : timer2_baud_clock_select_tb_top
`default_nettype wire
